// ### src/fpo_defines.vh
`ifndef FPO_DEFINES_VH
`define FPO_DEFINES_VH

// register byte offsets on the axi4-lite bus
`define FPO_OFS_PFLASH_PROT   8'h00
`define FPO_OFS_EEPROM_PROT   8'h04
`define FPO_OFS_OPTION        8'h08
`define FPO_OFS_RSV_TEST      8'h0C
`define FPO_OFS_STATUS        8'h10
`define FPO_OFS_CCOB_BASE     8'h14
`define FPO_CCOB_WORDS        6

// pflash protection register fields
`define FPO_PF_OPEN_BIT       7
`define FPO_PF_RNV_BIT        6
`define FPO_PF_HDIS_BIT       5
`define FPO_PF_HS_HI          4
`define FPO_PF_HS_LO          3
`define FPO_PF_LDIS_BIT       2
`define FPO_PF_LS_HI          1
`define FPO_PF_LS_LO          0

// eeprom protection register fields
`define FPO_EE_OPEN_BIT       7
`define FPO_EE_SIZE_HI        6
`define FPO_EE_SIZE_LO        0

// status register fields
`define FPO_ST_VIOL_BIT       0
`define FPO_ST_LOADED_BIT     1

// values held until the configuration field has been fetched, and values loaded on a fetch fault
`define FPO_PFLASH_RST        8'h7F
`define FPO_EEPROM_RST        8'h7F
`define FPO_OPTION_RST        8'hFF
`define FPO_EEPROM_DBF_VAL    8'h7F
`define FPO_OPTION_DBF_VAL    8'hFF

// protected eeprom granule is 32 bytes, so the size field compares addr[11:5]
`define FPO_EE_GRAN_LOG2      5

// axi responses
`define FPO_RESP_OKAY         2'b00
`define FPO_RESP_SLVERR       2'b10

`endif

// ### src/fpo_flash_prot.v
`timescale 1ns/1ps
`default_nettype none
`include "fpo_defines.vh"

// Operation
// - normal mode: pflash protection may only grow
// - disallowed transition write is dropped whole
// - pflash register reads back active scenario
// - scenario transition table gates every normal mode pflash write
// - normal mode eeprom write needs larger size
// - open bit set disables eeprom protection
// - special mode eeprom fields freely writable
// - eeprom protection loaded from configuration byte
// - eeprom fetch fault forces full protection
// - protected eeprom change refused, violation flag set
// - block erase refused if any sector protected
// - protected span is (size+1) times 32 bytes
// - open bit 7, size bits 6..0
// - option register read only
// - option bits loaded from configuration byte
// - option fetch fault sets all bits
// - reserved test register reads zero
// - six 16-bit command words, byte access
// - range sizes writable only while disabled
// - open/hdis/ldis select protection function
module fpo_flash_prot #(
  parameter EE_ADDR_W = 12
) (
  input  wire                 aclk,
  input  wire                 aresetn,
  input  wire                 special_mode,
  input  wire                 cfg_valid,
  input  wire [7:0]           cfg_pflash_byte,
  input  wire [7:0]           cfg_eeprom_byte,
  input  wire                 cfg_eeprom_dbf,
  input  wire [7:0]           cfg_option_byte,
  input  wire                 cfg_option_dbf,
  input  wire                 ee_op_valid,
  input  wire [EE_ADDR_W-1:0] ee_op_addr,
  input  wire                 ee_op_block_erase,
  output reg                  ee_op_done,
  output reg                  ee_op_refused,
  output wire [7:0]           pflash_protection_reg,
  output wire                 eeprom_prot_open,
  output wire [6:0]           eeprom_prot_size,
  output wire [7:0]           nonvolatile_option_bits,
  output wire                 protection_violation_flag,
  input  wire [7:0]           s_axi_awaddr,
  input  wire                 s_axi_awvalid,
  output wire                 s_axi_awready,
  input  wire [31:0]          s_axi_wdata,
  input  wire [3:0]           s_axi_wstrb,
  input  wire                 s_axi_wvalid,
  output wire                 s_axi_wready,
  output reg  [1:0]           s_axi_bresp,
  output reg                  s_axi_bvalid,
  input  wire                 s_axi_bready,
  input  wire [7:0]           s_axi_araddr,
  input  wire                 s_axi_arvalid,
  output wire                 s_axi_arready,
  output reg  [31:0]          s_axi_rdata,
  output reg  [1:0]           s_axi_rresp,
  output reg                  s_axi_rvalid,
  input  wire                 s_axi_rready
);

  reg [7:0]  pflash_q;
  reg [7:0]  eeprom_q;
  reg [7:0]  option_q;
  reg        viol_q;
  reg        loaded_q;
  reg [15:0] ccob_q [0:`FPO_CCOB_WORDS-1];
  reg        aw_held_q;
  reg        w_held_q;
  reg [7:0]  awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0]  wstrb_q;

  // allowed target scenarios per source scenario, bit n set = scenario n reachable
  function allowed_move;
    input [2:0] from_s;
    input [2:0] to_s;
    reg   [7:0] mask;
    begin
      case (from_s)
        3'd0:    mask = 8'h0F;
        3'd1:    mask = 8'h0A;
        3'd2:    mask = 8'h0C;
        3'd3:    mask = 8'h08;
        3'd4:    mask = 8'h18;
        3'd5:    mask = 8'h3C;
        3'd6:    mask = 8'h5A;
        default: mask = 8'hFF;
      endcase
      allowed_move = mask[to_s];
    end
  endfunction

  // word index of a ccob offset, 7 when outside the array
  function [2:0] ccob_index;
    input [7:0] addr;
    reg   [7:0] rel;
    begin
      rel = addr - `FPO_OFS_CCOB_BASE;
      if (addr >= `FPO_OFS_CCOB_BASE && rel[1:0] == 2'b00 && rel[7:2] < `FPO_CCOB_WORDS)
        ccob_index = rel[4:2];
      else
        ccob_index = 3'd7;
    end
  endfunction

  // scenario index is the open/hdis/ldis triple itself: 7 = 111 none, 3 = 011 full
  wire [2:0] cur_scen = {pflash_q[`FPO_PF_OPEN_BIT], pflash_q[`FPO_PF_HDIS_BIT],
                         pflash_q[`FPO_PF_LDIS_BIT]};

  // --- axi write channel ---
  assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_q && !s_axi_bvalid;

  wire       aw_fire = s_axi_awvalid && s_axi_awready;
  wire       w_fire  = s_axi_wvalid && s_axi_wready;
  wire [7:0] wr_addr = aw_held_q ? awaddr_q : s_axi_awaddr;
  wire [31:0] wr_data = w_held_q ? wdata_q : s_axi_wdata;
  wire [3:0] wr_strb = w_held_q ? wstrb_q : s_axi_wstrb;
  wire       wr_go   = (aw_held_q || aw_fire) && (w_held_q || w_fire);
  wire [2:0] wr_ccob = ccob_index(wr_addr);
  wire       wr_lane0 = wr_strb[0];

  // pflash candidate: size fields only move while their range is disabled
  reg  [7:0] pf_cand;
  always @* begin
    pf_cand = pflash_q;
    pf_cand[`FPO_PF_OPEN_BIT] = wr_data[`FPO_PF_OPEN_BIT];
    pf_cand[`FPO_PF_HDIS_BIT] = wr_data[`FPO_PF_HDIS_BIT];
    pf_cand[`FPO_PF_LDIS_BIT] = wr_data[`FPO_PF_LDIS_BIT];
    if (pflash_q[`FPO_PF_HDIS_BIT])
      pf_cand[`FPO_PF_HS_HI:`FPO_PF_HS_LO] = wr_data[`FPO_PF_HS_HI:`FPO_PF_HS_LO];
    if (pflash_q[`FPO_PF_LDIS_BIT])
      pf_cand[`FPO_PF_LS_HI:`FPO_PF_LS_LO] = wr_data[`FPO_PF_LS_HI:`FPO_PF_LS_LO];
  end

  wire [2:0] cand_scen = {pf_cand[`FPO_PF_OPEN_BIT], pf_cand[`FPO_PF_HDIS_BIT],
                          pf_cand[`FPO_PF_LDIS_BIT]};
  // special mode skips the transition table, normal mode enforces it
  wire pf_accept = special_mode || allowed_move(cur_scen, cand_scen);

  // eeprom: normal mode needs a larger size; open may only fall
  wire [6:0] ee_wsize   = wr_data[`FPO_EE_SIZE_HI:`FPO_EE_SIZE_LO];
  wire       ee_grow    = ee_wsize > eeprom_q[`FPO_EE_SIZE_HI:`FPO_EE_SIZE_LO];
  wire       ee_open_nm = eeprom_q[`FPO_EE_OPEN_BIT] & wr_data[`FPO_EE_OPEN_BIT];

  wire wr_known = (wr_addr == `FPO_OFS_PFLASH_PROT) || (wr_addr == `FPO_OFS_EEPROM_PROT) ||
                  (wr_addr == `FPO_OFS_OPTION) || (wr_addr == `FPO_OFS_RSV_TEST) ||
                  (wr_addr == `FPO_OFS_STATUS) || (wr_ccob != 3'd7);

  // --- eeprom protection check on program/erase requests ---
  wire ee_open   = eeprom_q[`FPO_EE_OPEN_BIT];
  wire [6:0] ee_size = eeprom_q[`FPO_EE_SIZE_HI:`FPO_EE_SIZE_LO];
  // span (size+1)*32 bytes from the eeprom base: granule index at or below size
  wire [EE_ADDR_W-`FPO_EE_GRAN_LOG2-1:0] op_gran = ee_op_addr[EE_ADDR_W-1:`FPO_EE_GRAN_LOG2];
  wire op_in_range = ({1'b0, op_gran} <= {{(EE_ADDR_W-`FPO_EE_GRAN_LOG2-6){1'b0}}, ee_size});
  wire op_block = ee_op_block_erase ? !ee_open : (!ee_open && op_in_range);
  wire viol_set = ee_op_valid && op_block;
  wire viol_clr = wr_go && wr_addr == `FPO_OFS_STATUS && wr_lane0 &&
                  wr_data[`FPO_ST_VIOL_BIT];

  // write side registers, response and the configuration load
  integer i;
  always @(posedge aclk) begin
    if (!aresetn) begin
      pflash_q     <= `FPO_PFLASH_RST;
      eeprom_q     <= `FPO_EEPROM_RST;
      option_q     <= `FPO_OPTION_RST;
      loaded_q     <= 1'b0;
      aw_held_q    <= 1'b0;
      w_held_q     <= 1'b0;
      awaddr_q     <= 8'h00;
      wdata_q      <= 32'h00000000;
      wstrb_q      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `FPO_RESP_OKAY;
      for (i = 0; i < `FPO_CCOB_WORDS; i = i + 1)
        ccob_q[i] <= 16'h0000;
    end else begin
      if (aw_fire && !wr_go) begin
        aw_held_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (w_fire && !wr_go) begin
        w_held_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (wr_go) begin
        aw_held_q    <= 1'b0;
        w_held_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_known ? `FPO_RESP_OKAY : `FPO_RESP_SLVERR;
        // a rejected write leaves every bit untouched
        if (wr_addr == `FPO_OFS_PFLASH_PROT && wr_lane0 && pf_accept)
          pflash_q <= pf_cand;
        if (wr_addr == `FPO_OFS_EEPROM_PROT && wr_lane0) begin
          if (special_mode)
            eeprom_q <= wr_data[7:0];
          else if (ee_grow)
            eeprom_q <= {ee_open_nm, ee_wsize};
        end
        // option and reserved test registers take no write data
        if (wr_ccob != 3'd7) begin
          if (wr_strb[0])
            ccob_q[wr_ccob][7:0] <= wr_data[7:0];
          if (wr_strb[1])
            ccob_q[wr_ccob][15:8] <= wr_data[15:8];
        end
      end
      // configuration field fetch finishing the reset sequence
      if (cfg_valid && !loaded_q) begin
        loaded_q <= 1'b1;
        pflash_q <= cfg_pflash_byte;
        eeprom_q <= cfg_eeprom_dbf ? `FPO_EEPROM_DBF_VAL : cfg_eeprom_byte;
        option_q <= cfg_option_dbf ? `FPO_OPTION_DBF_VAL : cfg_option_byte;
      end
    end
  end

  // violation flag: a new violation in the clear cycle wins
  always @(posedge aclk) begin
    if (!aresetn)
      viol_q <= 1'b0;
    else if (viol_set)
      viol_q <= 1'b1;
    else if (viol_clr)
      viol_q <= 1'b0;
  end

  // operation answer one cycle after the request
  always @(posedge aclk) begin
    if (!aresetn) begin
      ee_op_done    <= 1'b0;
      ee_op_refused <= 1'b0;
    end else begin
      ee_op_done    <= ee_op_valid;
      ee_op_refused <= viol_set;
    end
  end

  // --- axi read channel, one outstanding read ---
  assign s_axi_arready = !s_axi_rvalid;
  wire [2:0] rd_ccob = ccob_index(s_axi_araddr);

  reg [31:0] rd_word;
  reg        rd_ok;
  always @* begin
    rd_word = 32'h00000000;
    rd_ok   = 1'b1;
    case (s_axi_araddr)
      `FPO_OFS_PFLASH_PROT: rd_word[7:0] = pflash_q;
      `FPO_OFS_EEPROM_PROT: rd_word[7:0] = eeprom_q;
      `FPO_OFS_OPTION:      rd_word[7:0] = option_q;
      `FPO_OFS_RSV_TEST:    rd_word[7:0] = 8'h00;
      `FPO_OFS_STATUS: begin
        rd_word[`FPO_ST_VIOL_BIT]   = viol_q;
        rd_word[`FPO_ST_LOADED_BIT] = loaded_q;
      end
      default: begin
        if (rd_ccob != 3'd7)
          rd_word[15:0] = ccob_q[rd_ccob];
        else
          rd_ok = 1'b0;
      end
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `FPO_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_ok ? `FPO_RESP_OKAY : `FPO_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  assign pflash_protection_reg     = pflash_q;
  assign eeprom_prot_open          = eeprom_q[`FPO_EE_OPEN_BIT];
  assign eeprom_prot_size          = eeprom_q[`FPO_EE_SIZE_HI:`FPO_EE_SIZE_LO];
  assign nonvolatile_option_bits   = option_q;
  assign protection_violation_flag = viol_q;

endmodule // fpo_flash_prot

`default_nettype wire

// ### tb/fpo_flash_prot_chk.sv
`timescale 1ns/1ps
`default_nettype none
module fpo_flash_prot_chk #(
  parameter EE_ADDR_W = 12
) (
  input wire logic                 aclk,
  input wire logic                 aresetn,
  input wire logic                 special_mode,
  input wire logic                 cfg_valid,
  input wire logic                 ee_op_valid,
  input wire logic [EE_ADDR_W-1:0] ee_op_addr,
  input wire logic                 ee_op_block_erase,
  input wire logic                 ee_op_done,
  input wire logic                 ee_op_refused,
  input wire logic [7:0]           pflash_protection_reg,
  input wire logic                 eeprom_prot_open,
  input wire logic [6:0]           eeprom_prot_size,
  input wire logic [7:0]           nonvolatile_option_bits,
  input wire logic                 protection_violation_flag,
  input wire logic                 s_axi_arvalid,
  input wire logic                 s_axi_arready,
  input wire logic                 s_axi_rvalid
);
  // allowed moves, bit {from,to}; row 7 (no protection) sits at the top
  localparam logic [63:0] TBL = 64'hFF5A3C18080C0A0F;
  wire [2:0] scen = {pflash_protection_reg[7], pflash_protection_reg[5], pflash_protection_reg[2]};
  wire       hit  = ee_op_block_erase || (ee_op_addr[EE_ADDR_W-1:5] <= eeprom_prot_size);

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // a request seen while eeprom protection is active
  sequence s_shut;
    ee_op_valid && !eeprom_prot_open;
  endsequence

  a_done_timing: assert property (ee_op_done == $past(ee_op_valid))
    else $error("op done not one cycle after request");
  a_refuse_range: assert property (s_shut |=> ee_op_refused == $past(hit))
    else $error("refusal does not match protected range");
  a_open_free: assert property (ee_op_valid && eeprom_prot_open |=> !ee_op_refused)
    else $error("refused while protection open");
  a_flag_sets: assert property (ee_op_refused |-> protection_violation_flag)
    else $error("violation flag missing on refusal");
  a_option_fixed: assert property (!$past(cfg_valid) |-> $stable(nonvolatile_option_bits))
    else $error("option bits changed without load");
  a_pf_table: assert property (!$past(special_mode) && !$past(cfg_valid)
    |-> TBL[{$past(scen), scen}])
    else $error("pflash scenario moved illegally");
  a_ee_grow: assert property (!$past(special_mode) && !$past(cfg_valid)
    |-> !$rose(eeprom_prot_open) && eeprom_prot_size >= $past(eeprom_prot_size))
    else $error("eeprom protection reduced");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
endmodule // fpo_flash_prot_chk

bind fpo_flash_prot fpo_flash_prot_chk #(.EE_ADDR_W(EE_ADDR_W)) u_chk (
  .aclk, .aresetn, .special_mode, .cfg_valid, .ee_op_valid, .ee_op_addr, .ee_op_block_erase,
  .ee_op_done, .ee_op_refused, .pflash_protection_reg, .eeprom_prot_open, .eeprom_prot_size,
  .nonvolatile_option_bits, .protection_violation_flag, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid);
`default_nettype wire

// ### tb/fpo_flash_prot_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "fpo_defines.vh"
// count, compare and report one value
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin fail_count++; \
  $display("Error %s expected %h seen %h", nm, ex, got); end end
module fpo_flash_prot_test;
  localparam [7:0] PF = `FPO_OFS_PFLASH_PROT, EE = `FPO_OFS_EEPROM_PROT, ST = `FPO_OFS_STATUS;
  localparam [1:0] OK = `FPO_RESP_OKAY, SE = `FPO_RESP_SLVERR;
  logic        aclk = 0, aresetn = 0, special_mode = 0, cfg_valid = 0, dbf = 0;
  logic        ee_op_valid = 0, blk = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
  logic        rready = 0;
  logic [7:0]  pfb = 0, eeb = 0, opb = 0, awaddr = 0, araddr = 0;
  logic [11:0] ee_op_addr = 0;
  logic [31:0] wdata = 0, rd_d;
  logic [3:0]  wstrb = 0;
  logic [1:0]  rd_r;
  wire         ee_op_done, ee_op_refused, awready, wready, bvalid, arready, rvalid;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  wire  [7:0]  pf_o, opt_o;
  wire  [6:0]  ee_size_o;
  wire         ee_open_o, flag_o;
  int          fail_count = 0, comparisons = 0;

  fpo_flash_prot #(.EE_ADDR_W(12)) u_dut (.aclk, .aresetn, .special_mode, .cfg_valid,
    .cfg_pflash_byte(pfb), .cfg_eeprom_byte(eeb), .cfg_eeprom_dbf(dbf), .cfg_option_byte(opb),
    .cfg_option_dbf(dbf), .ee_op_valid, .ee_op_addr, .ee_op_block_erase(blk), .ee_op_done,
    .ee_op_refused, .pflash_protection_reg(pf_o), .eeprom_prot_open(ee_open_o),
    .eeprom_prot_size(ee_size_o), .nonvolatile_option_bits(opt_o),
    .protection_violation_flag(flag_o), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));

  // 100 MHz
  always #5 aclk = ~aclk;

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // handshakes are judged at the falling edge so the rising edge never races
  task automatic wr(input [7:0] a, input [31:0] d, input [3:0] s, input [1:0] er = OK);
    logic at, wt, bt;
    @(posedge aclk);
    awaddr <= a; wdata <= d; wstrb <= s; awvalid <= 1; wvalid <= 1; bready <= 1;
    for (int n = 0; n < 40; n++) begin
      @(negedge aclk);
      at = awvalid && awready; wt = wvalid && wready; bt = bvalid;
      if (bt) `CHK("write response", er, bresp)
      @(posedge aclk);
      if (at) awvalid <= 0;
      if (wt) wvalid <= 0;
      if (bt) begin
        bready <= 0;
        return;
      end
    end
    fail_count++;
    complete_run;
  endtask

  // read a word and compare data and response
  task automatic chkr(input string nm, input [7:0] a, input [31:0] ex, input [1:0] er = OK);
    logic at, bt;
    @(posedge aclk);
    araddr <= a; arvalid <= 1; rready <= 1;
    for (int n = 0; n < 40; n++) begin
      @(negedge aclk);
      at = arvalid && arready; bt = rvalid; rd_d = rdata; rd_r = rresp;
      @(posedge aclk);
      if (at) arvalid <= 0;
      if (bt) begin
        rready <= 0;
        `CHK({nm, " resp"}, er, rd_r)
        `CHK(nm, ex, rd_d)
        return;
      end
    end
    fail_count++;
    complete_run;
  endtask

  task automatic rst;
    @(posedge aclk);
    aresetn <= 0;
    repeat (12) @(posedge aclk);
    aresetn <= 1;
  endtask

  task automatic cfgp(input [7:0] p, input [7:0] e, input [7:0] o, input f);
    @(posedge aclk);
    pfb <= p; eeb <= e; opb <= o; dbf <= f; cfg_valid <= 1;
    @(posedge aclk);
    cfg_valid <= 0;
  endtask

  // one eeprom request; the answer is fixed at one cycle
  task automatic eeop(input [11:0] a, input b, input ex);
    @(posedge aclk);
    ee_op_addr <= a; blk <= b; ee_op_valid <= 1;
    @(posedge aclk);
    ee_op_valid <= 0;
    @(negedge aclk);
    `CHK("op done", 1'b1, ee_op_done)
    `CHK("op refused", ex, ee_op_refused)
  endtask

  // pflash byte for a scenario; size bits kept all ones so only the scenario moves
  function automatic [31:0] pb(input [2:0] s);
    return {24'h0, s[2], 1'b1, s[1], 2'b11, s[0], 2'b11};
  endfunction

  task automatic t_fault;
    cfgp(8'hFF, 8'h83, 8'h12, 1);
    chkr("eeprom", EE, 32'h7F);
    chkr("option", `FPO_OFS_OPTION, 32'hFF);
    wr(`FPO_OFS_OPTION, 32'h00, 4'h1);
    chkr("option", `FPO_OFS_OPTION, 32'hFF);
    wr(`FPO_OFS_RSV_TEST, 32'hFF, 4'h1);
    chkr("reserved", `FPO_OFS_RSV_TEST, 32'h0);
    wr(8'h40, 32'h1, 4'h1, SE);
    chkr("unmapped", 8'h40, 32'h0, SE);
    $display("test fault done");
  endtask

  task automatic t_load;
    chkr("pflash reset", PF, 32'h7F);
    chkr("status reset", ST, 32'h0);
    cfgp(8'hFF, 8'h83, 8'hA5, 0);
    chkr("pflash", PF, 32'hFF);
    chkr("eeprom", EE, 32'h83);
    chkr("option", `FPO_OFS_OPTION, 32'hA5);
    // pin outputs judged mid-cycle, well away from the launching edge
    @(negedge aclk);
    `CHK("pflash out", 8'hFF, pf_o)
    `CHK("open out", 1'b1, ee_open_o)
    `CHK("size out", 7'h03, ee_size_o)
    `CHK("option out", 8'hA5, opt_o)
    $display("test load done");
  endtask

  // from scenario 7: legal and illegal moves alternate
  task automatic t_pflash;
    int ws[6] = '{5, 1, 4, 2, 3, 7};
    int es[6] = '{5, 5, 4, 4, 3, 3};
    for (int i = 0; i < 6; i++) begin
      wr(PF, pb(ws[i][2:0]), 4'h1);
      chkr("pflash", PF, pb(es[i][2:0]));
    end
    $display("test pflash done");
  endtask

  task automatic t_eeprom;
    wr(EE, 32'h82, 4'h1);
    chkr("eeprom", EE, 32'h83);
    wr(EE, 32'h05, 4'h1);
    chkr("eeprom", EE, 32'h05);
    wr(EE, 32'h89, 4'h1);
    chkr("eeprom", EE, 32'h09);
    eeop(12'h13F, 0, 1);
    eeop(12'h140, 0, 0);
    eeop(12'h000, 1, 1);
    chkr("status", ST, 32'h3);
    @(negedge aclk);
    `CHK("flag out", 1'b1, flag_o)
    wr(ST, 32'h1, 4'h1);
    chkr("status", ST, 32'h2);
    @(negedge aclk);
    `CHK("flag out", 1'b0, flag_o)
    `CHK("open out", 1'b0, ee_open_o)
    `CHK("size out", 7'h09, ee_size_o)
    $display("test eeprom done");
  endtask

  task automatic t_special;
    @(posedge aclk);
    special_mode <= 1;
    // special mode skips the table; sizes still follow the pre-write disable bits
    wr(PF, 32'h00, 4'h1);
    chkr("pflash", PF, 32'h40);
    wr(PF, 32'hFF, 4'h1);
    chkr("pflash", PF, 32'hE4);
    wr(EE, 32'h80, 4'h1);
    chkr("eeprom", EE, 32'h80);
    eeop(12'h000, 1, 0);
    wr(EE, 32'h7F, 4'h1);
    eeop(12'hFFF, 0, 1);
    @(posedge aclk);
    special_mode <= 0;
    wr(`FPO_OFS_CCOB_BASE + 8'h08, 32'h1234, 4'h1);
    chkr("ccob", `FPO_OFS_CCOB_BASE + 8'h08, 32'h34);
    wr(`FPO_OFS_CCOB_BASE + 8'h08, 32'h5600, 4'h2);
    chkr("ccob", `FPO_OFS_CCOB_BASE + 8'h08, 32'h5634);
    $display("test special done");
  endtask

  initial begin
    rst;
    t_fault;
    rst;
    t_load;
    t_pflash;
    t_eeprom;
    t_special;
    complete_run;
  end
endmodule // fpo_flash_prot_test
`default_nettype wire
